// ===== src/brsc_pkg.sv
// Package with constants and types for the boot, reset and slow clock sequencer
package brsc_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h08;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h0c;
  localparam logic [7:0] OFF_WAKE_EN = 8'h10;
  localparam logic [7:0] OFF_BOOT    = 8'h14;

  // Control register fields
  localparam int CTRL_LOWPWR   = 0;
  localparam int CTRL_MAINON   = 1;
  localparam int CTRL_DL_REQ   = 2;
  localparam int CTRL_SRC_LSB  = 3;

  // Slow clock source modes
  typedef enum logic [1:0] {
    SRC_CRYSTAL = 2'b00,
    SRC_EXT     = 2'b01,
    SRC_DERIVED = 2'b10
  } brsc_src_t;

  // Detected slow clock class
  typedef enum logic [1:0] {
    DET_NONE  = 2'b00,
    DET_32K   = 2'b01,
    DET_3K2   = 2'b10
  } brsc_det_t;

  // Boot state machine, Gray along the usual path
  typedef enum logic [2:0] {
    BS_RESET  = 3'b000,
    BS_SAMPLE = 3'b001,
    BS_LISTEN = 3'b011,
    BS_FLASH  = 3'b010,
    BS_DLOAD  = 3'b110
  } brsc_boot_t;

  // Boot source encoding
  localparam logic [1:0] BOOT_NONE = 2'b00;
  localparam logic [1:0] BOOT_EXT  = 2'b01;
  localparam logic [1:0] BOOT_ROM  = 2'b10;

  // Reset values
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [11:0] WAKE_EN_RESET = 12'h000;
  localparam logic [11:0] MASK_RESET    = 12'h000;

  // Timing
  localparam int    CLK_HZ         = 40_000_000;
  localparam int    LISTEN_MS      = 1400;
  localparam int    MIN_RESET_MS   = 20;
  localparam longint LISTEN_CYCLES = longint'(CLK_HZ) * LISTEN_MS / 1000;
  localparam int    MAIN_HZ        = 13_000_000;
  localparam int    SLOW_HZ        = 32_768;
  // Detector window: 1 ms of system clock
  localparam int    DET_WIN_CYCLES = CLK_HZ / 1000;
  // Edges per 1 ms window: 32 kHz gives about 32, 3.2 kHz about 3
  localparam logic [7:0] DET_32K_MIN = 8'h14;
  localparam logic [7:0] DET_3K2_MIN = 8'h02;

  // Wake source layout: 2 irq lines, 8 gpio, usb, serial rx
  localparam int WAKE_W = 12;

  typedef struct packed {
    logic        usb;
    logic        rx;
    logic [7:0]  gpio;
    logic [1:0]  irq;
  } brsc_wake_t;

endpackage : brsc_pkg

// ===== src/brsc_frac_div.sv
// Fractional divider making an average slow tick from the main clock
`timescale 1ns/100ps
module brsc_frac_div
  import brsc_pkg::*;
#(
  parameter int REF_HZ = MAIN_HZ,
  parameter int OUT_HZ = SLOW_HZ
)(
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic en_i,
  output logic      tick_o
);
  import brsc_pkg::*;

  initial
  begin
    if (OUT_HZ <= 0 || OUT_HZ * 2 > REF_HZ)
      $error("Output rate not reachable");
  end

  // Accumulator wraps on average OUT_HZ times per REF_HZ ticks
  logic [31:0] acc_q;
  logic [31:0] acc_d;
  logic        tick_q;
  logic        tick_d;
  logic [32:0] sum;

  always_comb
  begin
    sum    = {1'b0, acc_q} + 33'(OUT_HZ);
    acc_d  = acc_q;
    tick_d = 1'b0;
    if (en_i)
    begin
      if (sum >= 33'(REF_HZ))
      begin
        acc_d  = 32'(sum - 33'(REF_HZ));
        tick_d = 1'b1;
      end
      else
      begin
        acc_d = sum[31:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      acc_q  <= 32'h0000_0000;
      tick_q <= 1'b0;
    end
    else
    begin
      acc_q  <= acc_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule : brsc_frac_div

// ===== src/brsc_top.sv
// Boot, reset and slow clock sequencer with APB registers
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module brsc_top
  import brsc_pkg::*;
#(
  parameter longint LISTEN_CNT = LISTEN_CYCLES
)(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        main_clk_i,
  input  wire logic        boot_strap_i,
  input  wire logic        xtal_clk_i,
  input  wire logic        slow_clk_in_i,
  input  wire logic        ext_irq_line_a_i,
  input  wire logic        ext_irq_line_b_i,
  input  wire logic [7:0]  gpio_i,
  input  wire logic        usb_activity_i,
  input  wire logic        serial_rx_i,
  input  wire logic        debug_serial_tx_i,
  input  wire logic        host_serial_tx_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             debug_serial_out_o,
  output logic             host_serial_out_o,
  output logic             cpu_run_o,
  output logic [1:0]       boot_src_o,
  output logic             timing_ref_o,
  output logic             wake_o,
  output logic             irq_o
);
  import brsc_pkg::*;

  initial
  begin
    if (LISTEN_CNT < 1 || LISTEN_CNT > 64'h0000_0000_FFFF_FFFF)
      $error("Listen count out of range");
  end

  // Two-flop synchronisers for every pin input except the two serial transmit lines
  localparam int NS = 16;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  assign pin_raw = {usb_activity_i, serial_rx_i, gpio_i, ext_irq_line_b_i,
                    ext_irq_line_a_i, boot_strap_i, xtal_clk_i, slow_clk_in_i,
                    main_clk_i};

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s1_q <= 16'h0000;
      s2_q <= 16'h0000;
    end
    else
    begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
    end
  end

  logic       main_s;
  logic       slow_s;
  logic       xtal_s;
  logic       strap_s;
  brsc_wake_t wake_s;
  assign main_s  = s2_q[0];
  assign slow_s  = s2_q[1];
  assign xtal_s  = s2_q[2];
  assign strap_s = s2_q[3];
  assign wake_s  = s2_q[15:4];

  // Registers; all take defaults under reset
  logic [31:0]       ctrl_q;
  logic [31:0]       ctrl_d;
  logic [WAKE_W-1:0] wen_q;
  logic [WAKE_W-1:0] wen_d;
  logic [WAKE_W-1:0] msk_q;
  logic [WAKE_W-1:0] msk_d;
  logic [WAKE_W-1:0] ist_q;
  logic [WAKE_W-1:0] ist_d;
  logic [WAKE_W-1:0] prev_q;

  logic wr_en;
  assign wr_en = psel_i && penable_i && pwrite_i;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_IRQ_ST) ||
              (a == OFF_IRQ_MSK) || (a == OFF_WAKE_EN) || (a == OFF_BOOT);
  endfunction : addr_ok

  // Boot sequencing
  brsc_boot_t bs_q;
  brsc_boot_t bs_d;
  logic [1:0] src_q;
  logic [1:0] src_d;
  logic [31:0] lcnt_q;
  logic [31:0] lcnt_d;

  always_comb
  begin
    bs_d   = bs_q;
    src_d  = src_q;
    lcnt_d = lcnt_q;
    case (bs_q)
      BS_RESET:
      begin
        // Wait an edge so the strap has crossed the synchroniser
        lcnt_d = lcnt_q + 32'h0000_0001;
        if (lcnt_q != 32'h0000_0000)
          bs_d = BS_SAMPLE;
      end
      BS_SAMPLE:
      begin
        // Strap taken once after release, then frozen
        src_d  = strap_s ? BOOT_EXT : BOOT_ROM;
        lcnt_d = 32'h0000_0000;
        bs_d   = strap_s ? BS_FLASH : BS_LISTEN;
      end
      BS_LISTEN:
      begin
        lcnt_d = lcnt_q + 32'h0000_0001;
        if (ctrl_q[CTRL_DL_REQ])
          bs_d = BS_DLOAD;
        else if (lcnt_q >= 32'(LISTEN_CNT - 1))
        begin
          bs_d  = BS_FLASH;
          src_d = BOOT_EXT;
        end
      end
      BS_FLASH:
        bs_d = BS_FLASH;
      BS_DLOAD:
        bs_d = BS_DLOAD;
      default:
        bs_d = BS_RESET;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      bs_q   <= BS_RESET;
      src_q  <= BOOT_NONE;
      lcnt_q <= 32'h0000_0000;
    end
    else
    begin
      bs_q   <= bs_d;
      src_q  <= src_d;
      lcnt_q <= lcnt_d;
    end
  end

  // Slow clock detection over a fixed window
  logic        det_prev_q;
  logic [7:0]  edges_q;
  logic [7:0]  edges_d;
  logic [31:0] win_q;
  logic [31:0] win_d;
  brsc_det_t   det_q;
  brsc_det_t   det_d;

  always_comb
  begin
    edges_d = edges_q;
    win_d   = win_q + 32'h0000_0001;
    det_d   = det_q;
    if (slow_s && !det_prev_q && edges_q != 8'hff)
      edges_d = edges_q + 8'h01;
    if (win_q >= 32'(DET_WIN_CYCLES - 1))
    begin
      win_d   = 32'h0000_0000;
      edges_d = 8'h00;
      if (edges_q >= DET_32K_MIN)
        det_d = DET_32K;
      else if (edges_q >= DET_3K2_MIN)
        det_d = DET_3K2;
      else
        det_d = DET_NONE;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      det_prev_q <= 1'b0;
      edges_q    <= 8'h00;
      win_q      <= 32'h0000_0000;
      det_q      <= DET_NONE;
    end
    else
    begin
      det_prev_q <= slow_s;
      edges_q    <= edges_d;
      win_q      <= win_d;
      det_q      <= det_d;
    end
  end

  // Slow clock source choice
  brsc_src_t src_mode;
  logic      frac_tick;
  logic      main_prev_q;
  logic      slow_sel;
  logic      sel_prev_q;

  always_comb
  begin
    if (ctrl_q[CTRL_MAINON])
      src_mode = SRC_DERIVED;
    else if (det_q != DET_NONE)
      src_mode = SRC_EXT;
    else
      src_mode = SRC_CRYSTAL;
  end

  // Divider steps on each synchronised main clock rising edge while in derived mode
  brsc_frac_div brsc_frac_div_inst (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .en_i   (main_s && !main_prev_q && src_mode == SRC_DERIVED),
    .tick_o (frac_tick)
  );

  always_comb
  begin
    case (src_mode)
      SRC_EXT:     slow_sel = slow_s && !det_prev_q;
      SRC_DERIVED: slow_sel = frac_tick;
      default:     slow_sel = xtal_s && !sel_prev_q;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      main_prev_q <= 1'b0;
      sel_prev_q  <= 1'b0;
    end
    else
    begin
      main_prev_q <= main_s;
      sel_prev_q  <= xtal_s;
    end
  end

  // Wake events: per-source enable, edge detect
  logic [WAKE_W-1:0] ev;
  assign ev = wake_s & ~prev_q;

  // Register block
  always_comb
  begin
    ctrl_d  = ctrl_q;
    wen_d   = wen_q;
    msk_d   = msk_q;
    ist_d   = ist_q;
    if (wr_en)
    begin
      case (paddr_i)
        OFF_CTRL:    ctrl_d = {27'h000_0000, pwdata_i[4:0]};
        OFF_IRQ_MSK: msk_d  = pwdata_i[WAKE_W-1:0];
        OFF_WAKE_EN: wen_d  = pwdata_i[WAKE_W-1:0];
        OFF_IRQ_ST:  ist_d  = ist_q & ~pwdata_i[WAKE_W-1:0];
        default:     ctrl_d = ctrl_q;
      endcase
    end
    // Set beats clear in the same cycle
    ist_d = ist_d | ev;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctrl_q  <= CTRL_RESET;
      wen_q   <= WAKE_EN_RESET;
      msk_q   <= MASK_RESET;
      ist_q   <= 12'h000;
      prev_q  <= 12'h000;
    end
    else
    begin
      ctrl_q  <= ctrl_d;
      wen_q   <= wen_d;
      msk_q   <= msk_d;
      ist_q   <= ist_d;
      prev_q  <= wake_s;
    end
  end

  // Zero-wait APB; read data registered at the setup cycle would be stale,
  // so answer comes combinationally from the freshly decoded value
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_ok(paddr_i);
  always_comb
  begin
    case (paddr_i)
      OFF_CTRL:    prdata_o = ctrl_q;
      OFF_STATUS:  prdata_o = {24'h00_0000, 1'b0, bs_q, det_q, src_mode};
      OFF_IRQ_ST:  prdata_o = {20'h0_0000, ist_q};
      OFF_IRQ_MSK: prdata_o = {20'h0_0000, msk_q};
      OFF_WAKE_EN: prdata_o = {20'h0_0000, wen_q};
      OFF_BOOT:    prdata_o = {30'h0000_0000, src_q};
      default:     prdata_o = 32'h0000_0000;
    endcase
  end

  // Outputs; transmit lines forced low while in reset
  logic hold_q;
  logic wake_q;
  logic tref_q;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hold_q <= 1'b1;
      wake_q <= 1'b0;
      tref_q <= 1'b0;
    end
    else
    begin
      hold_q <= 1'b0;
      wake_q <= |(ev & wen_q);
      // Low power swaps baseband reference to the slow tick
      tref_q <= ctrl_q[CTRL_LOWPWR] ? slow_sel : main_s;
    end
  end

  assign debug_serial_out_o = rstn_i && !hold_q && debug_serial_tx_i;
  assign host_serial_out_o  = rstn_i && !hold_q && host_serial_tx_i;
  assign cpu_run_o          = (bs_q != BS_RESET);
  assign boot_src_o         = src_q;
  assign timing_ref_o       = tref_q;
  assign wake_o             = wake_q;
  assign irq_o              = |(ist_q & msk_q);

endmodule : brsc_top

// ===== bench/brsc_board_model.sv
// Board model: main clock, crystal and external slow clock
`timescale 1ns/100ps
module brsc_board_model (
  input  wire logic ext_en_i,
  output logic      main_clk_o,
  output logic      xtal_clk_o,
  output logic      slow_clk_o
);
  logic main_q = 1'b0;
  logic xtal_q = 1'b0;
  logic ext_q  = 1'b0;
  always #38.5 main_q = ~main_q;
  always #15258.8 xtal_q = ~xtal_q;
  always #15258.8 ext_q = ~ext_q;
  assign main_clk_o = main_q;
  assign xtal_clk_o = xtal_q;
  // Held low when not fitted, so detection sees nothing
  assign slow_clk_o = ext_en_i & ext_q;
endmodule : brsc_board_model

// ===== bench/brsc_top_sva.sv
// Port checker for the sequencer top
`timescale 1ns/100ps
module brsc_top_sva
  import brsc_pkg::*;
#(
  parameter longint LISTEN_CNT = LISTEN_CYCLES
)(
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        cpu_run_o,
  input wire logic [1:0]  boot_src_o,
  input wire logic        wake_o,
  input wire logic        irq_o,
  input wire logic [7:0]  gpio_i,
  input wire logic        ext_irq_line_a_i,
  input wire logic        ext_irq_line_b_i,
  input wire logic        usb_activity_i,
  input wire logic        serial_rx_i
);
  logic [11:0] pins;
  logic [11:0] pin_q;
  logic [7:0]  hist_q;
  logic [31:0] rom_q;
  logic        acc;
  logic        bad;
  logic        mskw;
  assign pins = {usb_activity_i, serial_rx_i, gpio_i, ext_irq_line_b_i, ext_irq_line_a_i};
  assign acc  = psel_i && penable_i;
  assign bad  = !(paddr_i inside {OFF_CTRL, OFF_STATUS, OFF_IRQ_ST, OFF_IRQ_MSK,
                                  OFF_WAKE_EN, OFF_BOOT});
  assign mskw = acc && pwrite_i && paddr_i == OFF_IRQ_MSK;
  // Eight cycles of rise history cover the synchroniser lag
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_q  <= 12'h000;
      hist_q <= 8'h00;
      rom_q  <= 32'h0000_0000;
    end
    else
    begin
      pin_q  <= pins;
      hist_q <= {hist_q[6:0], |(pins & ~pin_q)};
      rom_q  <= (boot_src_o == BOOT_ROM) ? rom_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  a_ready_high: assert property (psel_i |-> pready_o) else $error("pready low");
  a_unmap_err: assert property (acc && bad |-> pslverr_o && (pwrite_i || prdata_o == 0))
    else $error("unmapped access not refused");
  a_map_ok: assert property (acc && !bad |-> !pslverr_o) else $error("mapped access refused");
  a_run_stays: assert property (cpu_run_o |=> cpu_run_o) else $error("run dropped");
  a_run_boot: assert property ($rose(cpu_run_o) |-> ##[0:3] boot_src_o != BOOT_NONE)
    else $error("no boot source after run");
  a_ext_fixed: assert property (boot_src_o == BOOT_EXT |=> boot_src_o == BOOT_EXT)
    else $error("boot source changed");
  a_rom_exit: assert property ($fell(boot_src_o == BOOT_ROM) |->
    boot_src_o == BOOT_EXT && rom_q inside {[LISTEN_CNT - 2 : LISTEN_CNT + 3]})
    else $error("listen length wrong");
  a_mask_clear: assert property (mskw && pwdata_i[11:0] == 12'h000 |=> !irq_o)
    else $error("irq with mask cleared");
  a_irq_cause: assert property ($rose(irq_o) |-> hist_q != 0 || $past(mskw))
    else $error("irq without cause");
  a_wake_cause: assert property (wake_o |-> hist_q != 0) else $error("wake without cause");
endmodule : brsc_top_sva

bind brsc_top brsc_top_sva #(.LISTEN_CNT(LISTEN_CNT)) brsc_top_sva_inst (.*);

// ===== bench/test_brsc_top.sv
// Self-checking bench for the sequencer
`timescale 1ns/100ps
module test_brsc_top;
  import brsc_pkg::*;
  localparam int LCNT = 100;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        strap = 1'b1;
  logic        ext_en = 1'b0;
  logic [1:0]  irq_ab = 2'h0;
  logic [7:0]  gpio = 8'h00;
  logic        usb = 1'b0;
  logic        rx = 1'b0;
  logic        tx_d = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        mclk, xclk, sclk, rdy, perr, err, dbg_o, host_o, run, tref, wake, irq;
  logic [1:0]  bsrc;
  int          err_count = 0;
  int          n_tests = 0;
  int          cnt;
  always #12.5 clk_i = ~clk_i;
  brsc_board_model brsc_board_model_inst (.ext_en_i(ext_en), .main_clk_o(mclk),
    .xtal_clk_o(xclk), .slow_clk_o(sclk));
  brsc_top #(.LISTEN_CNT(LCNT)) brsc_top_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .main_clk_i(mclk), .boot_strap_i(strap), .xtal_clk_i(xclk), .slow_clk_in_i(sclk),
    .ext_irq_line_a_i(irq_ab[0]), .ext_irq_line_b_i(irq_ab[1]), .gpio_i(gpio),
    .usb_activity_i(usb), .serial_rx_i(rx), .debug_serial_tx_i(tx_d),
    .host_serial_tx_i(tx_d), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prdata), .pready_o(rdy), .pslverr_o(perr),
    .debug_serial_out_o(dbg_o), .host_serial_out_o(host_o), .cpu_run_o(run),
    .boot_src_o(bsrc), .timing_ref_o(tref), .wake_o(wake), .irq_o(irq));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("Compared %0d, mismatched %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwd <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (rdy !== 1'b1 && k < 50);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_i);
    if (k >= 50)
    begin
      err_count++;
      test_done();
    end
  endtask : apb

  task automatic boot(input logic s);
    rstn_i <= 1'b0;
    strap <= s;
    // Hold cut far below the board's 20 ms to keep the run short
    repeat (5) @(posedge clk_i);
    check({dbg_o, host_o, run}, 3'b000);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : boot

  // Counts high samples of wake (sel 0) or timing reference (sel 1)
  task automatic count_high(input int n, input int sel);
    cnt = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      if ((sel == 0 ? wake : tref) === 1'b1)
        cnt++;
    end
  endtask : count_high

  initial
  begin
    boot(1'b1);
    check(bsrc, BOOT_EXT);
    check({run, dbg_o, host_o}, 3'b111);
    apb(1'b0, OFF_CTRL, 32'h0000_0000);
    check(rd, CTRL_RESET);
    apb(1'b0, OFF_IRQ_MSK, 32'h0000_0000);
    check(rd, {20'h0_0000, MASK_RESET});
    apb(1'b0, OFF_WAKE_EN, 32'h0000_0000);
    check(rd, {20'h0_0000, WAKE_EN_RESET});
    apb(1'b1, 8'h40, 32'hffff_ffff);
    check(err, 1'b1);
    apb(1'b0, 8'h40, 32'h0000_0000);
    check({err, rd[30:0]}, 32'h8000_0000);
    $display("Test external boot done");
    boot(1'b0);
    check(bsrc, BOOT_ROM);
    strap <= 1'b1;
    repeat (LCNT / 2) @(posedge clk_i);
    check(bsrc, BOOT_ROM);
    repeat (LCNT) @(posedge clk_i);
    check(bsrc, BOOT_EXT);
    boot(1'b0);
    apb(1'b1, OFF_CTRL, 32'h0000_0004);
    repeat (LCNT + 20) @(posedge clk_i);
    check(bsrc, BOOT_ROM);
    $display("Test ROM boot done");
    boot(1'b1);
    apb(1'b1, OFF_IRQ_MSK, 32'h0000_0fff);
    irq_ab <= 2'b01;
    gpio <= 8'h08;
    repeat (6) @(posedge clk_i);
    apb(1'b0, OFF_IRQ_ST, 32'h0000_0000);
    check({irq, rd[30:0]}, 32'h8000_0021);
    apb(1'b1, OFF_IRQ_MSK, 32'h0000_0000);
    check(irq, 1'b0);
    apb(1'b1, OFF_IRQ_ST, 32'h0000_0001);
    apb(1'b0, OFF_IRQ_ST, 32'h0000_0000);
    check(rd, 32'h0000_0020);
    apb(1'b1, OFF_WAKE_EN, 32'h0000_0800);
    rx <= 1'b1;
    count_high(10, 0);
    check(cnt, 0);
    usb <= 1'b1;
    count_high(10, 0);
    check(cnt, 1);
    $display("Test events done");
    // Low power must show sparse slow ticks, not the dense main clock
    for (int m = 1; m < 4; m += 2)
    begin
      apb(1'b1, OFF_CTRL, m);
      count_high(2500, 1);
      check(cnt inside {[1:5]}, 1'b1);
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      check(rd[1:0], (m == 1) ? SRC_CRYSTAL : SRC_DERIVED);
    end
    ext_en <= 1'b1;
    repeat (82000) @(posedge clk_i);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    check(rd[3:2], DET_32K);
    check(rd[1:0], SRC_DERIVED);
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    check(rd[1:0], SRC_EXT);
    count_high(2500, 1);
    check(cnt inside {[1:5]}, 1'b1);
    $display("Test slow clock done");
    test_done();
  end
endmodule : test_brsc_top
